// [design/arsq_top.sv]
// Auto-reclose sequencer: open time, close checks, close pulse, reclaim
`timescale 1ns/1ps
module arsq_top
    import arsq_pkg::*;
#(
    parameter int unsigned CLK_PER_MS = CLK_PER_MS_DEF,
    parameter int unsigned TW         = TIME_W
)(
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_b,
    input  wire logic                        i_ce,
    input  wire logic                        i_start,
    input  wire logic                        i_fast_start,
    input  wire logic                        i_two_phase_trip,
    input  wire logic                        i_three_phase_trip,
    input  wire logic                        i_onto_fault_trip,
    input  wire logic                        i_permissive_link_lost,
    input  wire logic                        i_phase_match_ok,
    input  wire logic                        i_breaker_energy_ok,
    input  wire logic                        i_breaker_closed,
    input  wire logic                        i_sequence_block,
    input  wire logic                        i_counter_clear,
    input  wire logic                        i_single_phase_prog,
    input  wire logic                        i_open_time_extend_en,
    input  wire logic                        i_close_pulse_cut_en,
    input  wire logic                        i_readiness_co,
    input  wire logic                        i_failure_by_position_sel,
    input  wire logic                        i_auto_proceed_en,
    input  wire logic                        i_open_position_start_en,
    input  wire logic [2:0]                  i_shot_limit,
    input  wire logic [TW-1:0]               i_open_time_1ph,
    input  wire logic [TW-1:0]               i_open_time_2ph,
    input  wire logic [TW-1:0]               i_open_time_3ph,
    input  wire logic [TW-1:0]               i_open_time_fast,
    input  wire logic [TW-1:0]               i_open_time_later,
    input  wire logic [TW-1:0]               i_open_time_extension,
    input  wire logic [TW-1:0]               i_max_trip_time,
    input  wire logic [TW-1:0]               i_match_wait_time,
    input  wire logic [TW-1:0]               i_reclaim_time,
    input  wire logic [TW-1:0]               i_close_pulse_time,
    input  wire logic [TW-1:0]               i_failed_close_time,
    input  wire logic [TW-1:0]               i_auto_proceed_delay,
    output logic                             o_breaker_close,
    output logic                             o_reclose_failed,
    output logic                             o_ready,
    output logic                             o_active,
    output logic                             o_blocked,
    output logic [2:0]                       o_shot,
    output logic [N_CNT-1:0][CNT_W-1:0]      o_type_count,
    output logic [CNT_W-1:0]                 o_total_reclose_count
);

    localparam int unsigned PW = $clog2(CLK_PER_MS + 1);

    function automatic logic elapsed(input logic [TW-1:0] t, input logic [TW-1:0] lim);
        return t >= lim;
    endfunction : elapsed

    function automatic logic [TW-1:0] inc_sat(input logic [TW-1:0] t, input logic tk);
        return (tk && t != '1) ? t + TW'(1) : t;
    endfunction : inc_sat

    arsq_state_t       state_reg;
    arsq_state_t       state_next;
    arsq_kind_t        kind_reg;
    logic [PW-1:0]     pre_reg;
    logic              tick_reg;
    logic              trip_d_reg;
    logic              rep_d_reg;
    logic              closed_d_reg;
    logic              hs_reg;
    logic              ext_reg;
    logic              cut_reg;
    logic              rep_pend_reg;
    logic              pos_ok_reg;
    logic [2:0]        shot_reg;
    logic [TW-1:0]     dead_reg;
    logic [TW-1:0]     tmr_reg;
    logic [TW-1:0]     rcl_reg;
    logic [TW-1:0]     trip_tmr_reg;
    logic              trip;
    logic              trip_rise;
    logic              rep_rise;
    logic              rep_ev;
    logic              open_edge;
    logic              start_any;
    logic              start_ok;
    logic              close_ok;
    logic              long_trip;
    logic              dead_done;
    logic              pulse_end;
    logic              reclaim_done;
    logic              more_shots;
    logic              next_shot;
    logic              pos_fail;
    logic              close_cmd;
    logic [TW:0]       dead_lim;

    arsq_cnt_if cif ();

    // ****************************************************************
    // Millisecond time base and input edges
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (i_ce) begin
            if (pre_reg == PW'(CLK_PER_MS - 1)) begin
                pre_reg  <= '0;
                tick_reg <= 1'b1;
            end else begin
                pre_reg  <= pre_reg + PW'(1);
                tick_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            trip_d_reg   <= 1'b0;
            rep_d_reg    <= 1'b0;
            closed_d_reg <= 1'b0;
        end else if (i_ce) begin
            trip_d_reg   <= trip;
            rep_d_reg    <= i_start | i_onto_fault_trip;
            closed_d_reg <= i_breaker_closed;
        end
    end

    // ****************************************************************
    // Sequence decisions
    // ****************************************************************
    always_comb begin
        trip      = i_start | i_fast_start | i_onto_fault_trip
                  | i_two_phase_trip | i_three_phase_trip;
        trip_rise = trip & ~trip_d_reg;
        rep_rise  = (i_start | i_onto_fault_trip) & ~rep_d_reg;
        rep_ev    = rep_rise | rep_pend_reg;
        open_edge = i_open_position_start_en & closed_d_reg & ~i_breaker_closed;
        start_any = i_start | i_fast_start | open_edge;
        start_ok  = i_breaker_energy_ok & closed_d_reg & ~i_sequence_block;
        close_ok  = (i_phase_match_ok | kind_reg != K_3P | hs_reg)
                  & (~i_readiness_co | i_breaker_energy_ok);
        dead_lim  = {1'b0, dead_reg} + (ext_reg ? {1'b0, i_open_time_extension} : '0);
        dead_done = {1'b0, tmr_reg} >= dead_lim;
        long_trip = state_reg == S_DEAD && trip && elapsed(trip_tmr_reg, i_max_trip_time);
        pulse_end = elapsed(tmr_reg, MIN_PULSE_MS)
                  & (elapsed(tmr_reg, i_close_pulse_time)
                  | (i_close_pulse_cut_en & (cut_reg | trip_rise)));
        reclaim_done = elapsed(rcl_reg, i_reclaim_time);
        more_shots   = shot_reg < i_shot_limit;
        next_shot    = more_shots & (rep_ev
                     | (i_auto_proceed_en & ~i_breaker_closed
                        & elapsed(rcl_reg, i_auto_proceed_delay)));
        pos_fail     = i_failure_by_position_sel & ~pos_ok_reg
                     & elapsed(rcl_reg, i_failed_close_time);
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            S_IDLE: begin
                if (start_any && start_ok) begin
                    state_next = S_DEAD;
                end
            end
            S_DEAD: begin
                if (i_sequence_block || (long_trip && !i_open_time_extend_en)) begin
                    state_next = S_BLOCKED;
                end else if (dead_done) begin
                    state_next = S_CHECK;
                end
            end
            S_CHECK: begin
                if (i_sequence_block) begin
                    state_next = S_BLOCKED;
                end else if (close_ok) begin
                    state_next = S_CLOSE;
                end else if (elapsed(tmr_reg, i_match_wait_time)) begin
                    state_next = S_BLOCKED;
                end
            end
            S_CLOSE: begin
                if (i_sequence_block) begin
                    state_next = S_BLOCKED;
                end else if (pulse_end) begin
                    state_next = S_RECLAIM;
                end
            end
            S_RECLAIM: begin
                if (i_sequence_block) begin
                    state_next = S_BLOCKED;
                end else if (next_shot) begin
                    state_next = S_DEAD;
                end else if (reclaim_done) begin
                    state_next = S_IDLE;
                end
            end
            S_BLOCKED: begin
                if (!i_sequence_block && !trip) begin
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    assign close_cmd = state_reg != S_CLOSE && state_next == S_CLOSE;

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= S_IDLE;
        end else if (i_ce) begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // Shot context
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shot_reg <= SHOT_RST;
            kind_reg <= K_3P;
            hs_reg   <= 1'b0;
            ext_reg  <= 1'b0;
            dead_reg <= '0;
        end else if (i_ce) begin
            if (state_reg == S_IDLE && state_next == S_DEAD) begin
                shot_reg <= SHOT_FIRST;
                hs_reg   <= i_fast_start;
                ext_reg  <= i_open_time_extend_en & i_permissive_link_lost;
                if (i_fast_start) begin
                    kind_reg <= K_3P;
                    dead_reg <= i_open_time_fast;
                end else if (i_two_phase_trip || i_three_phase_trip) begin
                    kind_reg <= K_2P;
                    dead_reg <= i_open_time_2ph;
                end else if (i_single_phase_prog) begin
                    kind_reg <= K_1P;
                    dead_reg <= i_open_time_1ph;
                end else begin
                    kind_reg <= K_3P;
                    dead_reg <= i_open_time_3ph;
                end
            end else if (state_reg == S_RECLAIM && state_next == S_DEAD) begin
                shot_reg <= shot_reg + 3'h1;
                kind_reg <= K_3P;
                hs_reg   <= 1'b0;
                ext_reg  <= 1'b0;
                dead_reg <= i_open_time_later;
            end else if (long_trip && i_open_time_extend_en) begin
                ext_reg  <= 1'b1;
            end else if (state_next == S_IDLE) begin
                shot_reg <= SHOT_RST;
            end
        end
    end

    // ****************************************************************
    // Timers
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tmr_reg      <= '0;
            rcl_reg      <= '0;
            trip_tmr_reg <= '0;
        end else if (i_ce) begin
            tmr_reg      <= (state_next != state_reg) ? '0 : inc_sat(tmr_reg, tick_reg);
            rcl_reg      <= close_cmd ? '0 : inc_sat(rcl_reg, tick_reg);
            trip_tmr_reg <= trip ? inc_sat(trip_tmr_reg, tick_reg) : '0;
        end
    end

    // ****************************************************************
    // Close pulse, repeat trips and failure flag
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cut_reg      <= 1'b0;
            rep_pend_reg <= 1'b0;
            pos_ok_reg   <= 1'b0;
        end else if (i_ce) begin
            cut_reg      <= state_reg == S_CLOSE && (cut_reg || trip_rise);
            rep_pend_reg <= state_reg == S_CLOSE && (rep_pend_reg || rep_rise);
            pos_ok_reg   <= !close_cmd && (pos_ok_reg || i_breaker_closed);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reclose_failed <= 1'b0;
        end else if (i_ce) begin
            if ((state_reg == S_CLOSE || state_reg == S_RECLAIM)
                && (rep_rise || pos_fail)) begin
                o_reclose_failed <= 1'b1;
            end else if (state_reg == S_RECLAIM && reclaim_done) begin
                o_reclose_failed <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Registered outputs and counters
    // ****************************************************************
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_breaker_close <= 1'b0;
            o_ready         <= 1'b0;
            o_active        <= 1'b0;
            o_blocked       <= 1'b0;
            o_shot          <= SHOT_RST;
        end else if (i_ce) begin
            o_breaker_close <= state_next == S_CLOSE;
            o_ready         <= state_next == S_IDLE && start_ok;
            o_active        <= state_next != S_IDLE && state_next != S_BLOCKED;
            o_blocked       <= state_next == S_BLOCKED;
            o_shot          <= shot_reg;
        end
    end

    assign cif.inc = close_cmd & i_ce;
    assign cif.idx = (kind_reg == K_1P) ? IDX_1P :
                     (kind_reg == K_2P) ? IDX_2P : IDX_3P0 + shot_reg;
    assign cif.clr = i_counter_clear;
    assign o_type_count          = cif.cnt;
    assign o_total_reclose_count = cif.total;

    arsq_counters u_counters (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_ce    (i_ce),
        .cif     (cif)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_b);

    a_pulse_min: assert property (
        ($fell(o_breaker_close) && $past(!i_sequence_block)) |-> $past(tmr_reg) >= MIN_PULSE_MS)
        else $error("close pulse shorter than minimum");
    a_pulse_len: assert property (
        ($fell(o_breaker_close) && $past(!i_sequence_block && !i_close_pulse_cut_en))
        |-> $past(tmr_reg) >= $past(i_close_pulse_time))
        else $error("close pulse shorter than setting");
    a_reclaim_start: assert property ($rose(o_breaker_close) |-> rcl_reg == '0)
        else $error("reclaim timer not started at close");
    a_phase_gate: assert property (
        (state_reg == S_CHECK && kind_reg == K_3P && !hs_reg && !i_phase_match_ok)
        |-> state_next != S_CLOSE)
        else $error("close without phase match");
    a_energy_gate: assert property (
        (state_reg == S_CHECK && i_readiness_co && !i_breaker_energy_ok)
        |-> state_next != S_CLOSE)
        else $error("close without breaker energy");
    a_match_abort: assert property (
        (i_ce && state_reg == S_CHECK && !close_ok && elapsed(tmr_reg, i_match_wait_time))
        |=> (state_reg == S_BLOCKED && o_blocked))
        else $error("wait time expiry did not block");
    a_ready_open: assert property ((i_ce && !closed_d_reg) |=> !o_ready)
        else $error("ready while breaker open");
    a_fail_set: assert property (
        (i_ce && rep_rise && (state_reg == S_CLOSE || state_reg == S_RECLAIM))
        |=> o_reclose_failed)
        else $error("repeat trip not flagged");
    a_fail_clear: assert property (
        (i_ce && state_reg == S_RECLAIM && reclaim_done && !rep_rise && !pos_fail)
        |=> !o_reclose_failed)
        else $error("failure flag held past reclaim");

endmodule : arsq_top

// [design/arsq_pkg.sv]
// Constants, types and settings for the auto-reclose sequencer
// Overview of operation
// - Single-phase program, plain start: single-phase open time
// - Two/three-phase trip with start: two-phase open time
// - Fast start uses high-speed three-phase open time
// - Extension enabled and link lost: add extension
// - Overlong trip lengthens open time by extension
// - Extension off: overlong trip aborts like blocking
// - Phase match required only on delayed three-phase shots
// - Close-open readiness also needs breaker energy
// - Close conditions missing past wait time: block
// - Reclaim starts at close; trips continue fault
// - Close pulse lasts the longer of the close pulse time and 50 ms
// - Cut enabled: new trip ends pulse early
// - Close pulse shorter than 50 ms only when blocking ends it
// - Close increments type counter and total
// - Reclaim expiry without trip resets sequence
// - Repeat trip after close flags failed reclose
// - After repeat, only further delayed shots allowed
// - Failed flag drops when reclaim time elapses
// - Position check: breaker stays open, flag failure
// - Auto proceed to next shot after delay
// - Closed-to-open change produces one-cycle start pulse
// - Not ready while breaker reads open
// - Start needs energy, closed breaker, no blocking
package arsq_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned CLK_PER_MS_DEF = CLK_HZ / MS_PER_S;
    localparam int unsigned TIME_W         = 16;
    localparam logic [15:0] MIN_PULSE_MS   = 16'h0032;

    // ****************************************************************
    // Counters
    // ****************************************************************
    localparam int unsigned CNT_W   = 16;
    localparam int unsigned N_CNT   = 7;
    localparam logic [2:0]  IDX_1P  = 3'h0;
    localparam logic [2:0]  IDX_2P  = 3'h1;
    localparam logic [2:0]  IDX_3P0 = 3'h1;
    localparam logic [2:0]  SHOT_RST = 3'h0;
    localparam logic [2:0]  SHOT_FIRST = 3'h1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [5:0] {
        S_IDLE    = 6'h01,
        S_DEAD    = 6'h02,
        S_CHECK   = 6'h04,
        S_CLOSE   = 6'h08,
        S_RECLAIM = 6'h10,
        S_BLOCKED = 6'h20
    } arsq_state_t;

    typedef enum logic [1:0] {
        K_1P = 2'h0,
        K_2P = 2'h1,
        K_3P = 2'h2
    } arsq_kind_t;

endpackage : arsq_pkg

// [design/arsq_cnt_if.sv]
// Carrier between the sequencer and its operation counter bank
`timescale 1ns/1ps
interface arsq_cnt_if
    import arsq_pkg::*;
();
    logic                          inc;
    logic [2:0]                    idx;
    logic                          clr;
    logic [N_CNT-1:0][CNT_W-1:0]   cnt;
    logic [CNT_W-1:0]              total;

    modport seq  (output inc, output idx, output clr, input cnt, input total);
    modport bank (input inc, input idx, input clr, output cnt, output total);
endinterface : arsq_cnt_if

// [design/arsq_counters.sv]
// Reclose operation counters, one per type and shot plus a total
`timescale 1ns/1ps
module arsq_counters
    import arsq_pkg::*;
(
    input  wire logic  i_mclk,
    input  wire logic  i_rst_b,
    input  wire logic  i_ce,
    arsq_cnt_if.bank   cif
);

    // ****************************************************************
    // Per-type counters
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < N_CNT; g++) begin : g_cnt
            always_ff @(posedge i_mclk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    cif.cnt[g] <= '0;
                end else if (i_ce) begin
                    if (cif.clr) begin
                        cif.cnt[g] <= '0;
                    end else if (cif.inc && cif.idx == 3'(g)) begin
                        cif.cnt[g] <= cif.cnt[g] + CNT_W'(1);
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cif.total <= '0;
        end else if (i_ce) begin
            if (cif.clr) begin
                cif.total <= '0;
            end else if (cif.inc) begin
                cif.total <= cif.total + CNT_W'(1);
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_total_inc: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && cif.inc && !cif.clr) |=> cif.total == $past(cif.total) + CNT_W'(1))
        else $error("total count did not follow close command");
    a_count_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (i_ce && cif.clr) |=> (cif.total == '0 && cif.cnt == '0))
        else $error("counters not zero after clear");

endmodule : arsq_counters

// [testbench/arsq_breaker_model.sv]
// Breaker contact model: opens on a trip, closes on the close command
`timescale 1ns/1ps
module arsq_breaker_model (
    input  wire logic i_mclk,
    input  wire logic i_rst_b,
    input  wire logic i_trip,
    input  wire logic i_close_cmd,
    output logic      o_closed
);
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_closed <= 1'b1;
        end else if (i_trip) begin
            o_closed <= 1'b0;
        end else if (i_close_cmd) begin
            o_closed <= 1'b1;
        end
    end
endmodule : arsq_breaker_model

// [testbench/tb_top.sv]
// Self-checking bench for the auto-reclose sequencer
`timescale 1ns/1ps
module tb_top;
    import arsq_pkg::*;
    logic                        clk, rst_b, start, tp2, clr, cls, fb, ready, active, fail;
    logic [7:0]                  cfg;
    logic [2:0]                  shot;
    logic [15:0]                 t1, t2, tp, tr, tl;
    logic [N_CNT-1:0][CNT_W-1:0] cnt;
    logic [CNT_W-1:0]            tot;
    int                          n_fail = 0;
    int                          n_checks = 0;
    int                          w;
    arsq_breaker_model i_cb (.i_mclk(clk), .i_rst_b(rst_b), .i_trip(start),
        .i_close_cmd(cls), .o_closed(fb));
    arsq_top #(.CLK_PER_MS(4)) i_dut (.i_mclk(clk), .i_rst_b(rst_b), .i_ce(cfg[7]),
        .i_start(start), .i_fast_start(cfg[0]), .i_two_phase_trip(tp2),
        .i_three_phase_trip(cfg[0]), .i_onto_fault_trip(cfg[0]),
        .i_permissive_link_lost(cfg[0]), .i_phase_match_ok(cfg[0]),
        .i_breaker_energy_ok(cfg[7]), .i_breaker_closed(fb), .i_sequence_block(cfg[1]),
        .i_counter_clear(clr), .i_single_phase_prog(cfg[7]),
        .i_open_time_extend_en(cfg[2]), .i_close_pulse_cut_en(cfg[3]),
        .i_readiness_co(cfg[4]), .i_failure_by_position_sel(cfg[5]),
        .i_auto_proceed_en(cfg[6]), .i_open_position_start_en(cfg[6]),
        .i_shot_limit(3'h1), .i_open_time_1ph(t1), .i_open_time_2ph(t2),
        .i_open_time_3ph(tl), .i_open_time_fast(tl), .i_open_time_later(tl),
        .i_open_time_extension(tl), .i_max_trip_time(tl), .i_match_wait_time(tl),
        .i_reclaim_time(tr), .i_close_pulse_time(tp), .i_failed_close_time(tl),
        .i_auto_proceed_delay(tl), .o_breaker_close(cls), .o_reclose_failed(fail),
        .o_ready(ready), .o_active(active), .o_blocked(), .o_shot(shot),
        .o_type_count(cnt), .o_total_reclose_count(tot));
    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    // A wait that used up its bound counts as a mismatch and ends the run
    task automatic limit_hit;
        if (w >= 4000) begin
            n_fail++;
            close_out;
        end
    endtask : limit_hit
    // Start one shot; phase match stays low, single and two-phase shots ignore it.
    // With rep set, a repeat start lands in the reclaim time and leaves the breaker open.
    task automatic run(input logic two, input int ot, input int idx, input logic rep);
        start <= 1'b1;
        tp2 <= two;
        @(posedge clk);
        start <= 1'b0;
        tp2 <= 1'b0;
        w = 0;
        while (cls !== 1'b1 && w < 4000) begin
            @(negedge clk);
            w++;
        end
        limit_hit;
        check(shot, 1);
        check(w >= ot * 4 && w <= ot * 4 + 12, 1);
        w = 0;
        while (cls === 1'b1 && w < 4000) begin
            @(negedge clk);
            w++;
        end
        limit_hit;
        check((w + 2) / 4, 50);
        check(cnt[idx], 1);
        if (rep) begin
            @(posedge clk);
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            @(negedge clk);
        end
        check(fail, rep);
        w = 0;
        while (active !== 1'b0 && w < 4000) begin
            @(negedge clk);
            w++;
        end
        limit_hit;
        check(fail, 0);
        repeat (3) @(posedge clk);
        check(ready, !rep);
        check(shot, 0);
    endtask : run
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_b, start, tp2, clr} = 4'h0;
        cfg = 8'h80;
        t1 = 16'h0014;
        t2 = 16'h0028;
        tp = 16'h000A;
        tr = 16'h0050;
        tl = 16'h03E8;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        run(1'b0, 20, 0, 1'b0);
        run(1'b1, 40, 1, 1'b0);
        check(tot, 2);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (3) @(posedge clk);
        check(tot, 0);
        check(cnt[1], 0);
        run(1'b0, 20, 0, 1'b1);
        close_out;
    end
endmodule : tb_top
